// [pkg/sirq_pkg.sv]
// constants and types shared by both ends of the serial interrupt link
package sirq_pkg;
    localparam int         NUM_FRAMES = 21;
    localparam logic [3:0] START_MIN  = 4'h4;
    localparam logic [3:0] START_MAX  = 4'h8;
    localparam logic [3:0] STOP_QUIET = 4'h2;
    localparam logic [3:0] STOP_CONT  = 4'h3;
    localparam logic [3:0] LOW_SAT    = 4'hf;
    localparam logic [2:0] EXT_MIN    = 3'h3;
    localparam logic [2:0] EXT_MAX    = 3'h7;
    localparam logic [5:0] FRAME_INIT = 6'h3f;
    localparam logic [5:0] FRAME_SAT  = 6'h20;
    localparam logic [5:0] LAST_FRAME = 6'h14;

    typedef enum logic [1:0] {PH_SAMPLE, PH_RECOV, PH_TURN} sirq_phase_t;
    typedef enum logic [1:0] {DS_IDLE, DS_WAKE, DS_FRAMES} sirq_dev_state_t;
    typedef enum logic [2:0]
    {
        HS_IDLE,
        HS_START,
        HS_START_HI,
        HS_FRAMES,
        HS_STOP,
        HS_STOP_HI
    } sirq_host_state_t;
endpackage

// [pkg/sirq_if.sv]
// shared open-drain serial interrupt line joining device and host ends
`timescale 1ns/100ps
interface sirq_if;
    logic link_clk;
    logic dev_out;
    logic dev_oe_n;
    logic host_out;
    logic host_oe_n;
    wire  shared_interrupt_line;

    // any enabled low driver wins; otherwise the pull-up or a high driver
    assign shared_interrupt_line = ((!dev_oe_n && !dev_out) || (!host_oe_n && !host_out))
                                   ? 1'b0 : 1'b1;

    modport device
    (
        input  link_clk,
        input  shared_interrupt_line,
        output dev_out,
        output dev_oe_n
    );
    modport host
    (
        input  link_clk,
        input  shared_interrupt_line,
        output host_out,
        output host_oe_n
    );
endinterface

// [src/sirq_host.sv]
// host end: issues start and stop frames and collects the interrupt frames
`timescale 1ns/100ps
module sirq_host
(
    input  wire logic                              sys_clk_in,
    input  wire logic                              rst_in,
    input  wire logic                              start_req_in,
    input  wire logic                              quiet_next_in,
    input  wire logic [2:0]                        start_ext_in,
    output logic      [sirq_pkg::NUM_FRAMES-1:0]   irq_out,
    output logic                                   cycle_done_out,
    output logic                                   busy_out,
    output logic                                   quiet_mode_out,
    sirq_if.host                                   link
);
    import sirq_pkg::*;

    logic                   clk_s1_q;
    logic                   clk_s2_q;
    logic                   clk_s3_q;
    logic                   line_s1_q;
    logic                   line_s2_q;
    logic                   tick;
    logic [2:0]             ext;
    sirq_host_state_t       st_q, st_d;
    sirq_phase_t            phase_q, phase_d;
    logic [5:0]             frame_q, frame_d;
    logic [3:0]             cnt_q, cnt_d;
    logic                   quiet_q, quiet_d;
    logic                   req_q, req_d;
    logic                   drv_q, drv_d;
    logic                   oe_n_q, oe_n_d;
    logic [NUM_FRAMES-1:0]  cap_q, cap_d;
    logic [NUM_FRAMES-1:0]  irq_q, irq_d;
    logic                   done_q, done_d;
    logic                   busy_q, busy_d;

    // link clock and line both pass two flops before use
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            // reset high: a link clock already high at release gives no false tick
            clk_s1_q  <= 1'b1;
            clk_s2_q  <= 1'b1;
            clk_s3_q  <= 1'b1;
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
        end
        else
        begin
            clk_s1_q  <= link.link_clk;
            clk_s2_q  <= clk_s1_q;
            clk_s3_q  <= clk_s2_q;
            line_s1_q <= link.shared_interrupt_line;
            line_s2_q <= line_s1_q;
        end
    end

    assign tick = clk_s2_q & ~clk_s3_q; // [R2]
    assign ext  = (start_ext_in < EXT_MIN) ? EXT_MIN : start_ext_in; // [R5]

    always_comb
    begin
        st_d    = st_q;
        phase_d = phase_q;
        frame_d = frame_q;
        cnt_d   = cnt_q;
        quiet_d = quiet_q;
        req_d   = req_q | start_req_in;
        drv_d   = drv_q;
        oe_n_d  = oe_n_q;
        cap_d   = cap_q;
        irq_d   = irq_q;
        done_d  = 1'b0;
        if (tick)
        begin
            case (st_q)
                HS_IDLE:
                begin
                    drv_d  = 1'b1;
                    oe_n_d = 1'b1;
                    if (quiet_q && !line_s2_q)
                    begin
                        // a peripheral woke the line; hold it low from this clock on
                        drv_d  = 1'b0; // [R5]
                        oe_n_d = 1'b0; // [R1]
                        cnt_d  = {1'b0, ext};
                        st_d   = HS_START;
                    end
                    else if (!quiet_q && req_q && line_s2_q)
                    begin
                        drv_d  = 1'b0; // [R7]
                        oe_n_d = 1'b0;
                        cnt_d  = {1'b0, ext} + 4'h1;
                        req_d  = start_req_in;
                        st_d   = HS_START;
                    end
                end
                HS_START, HS_STOP:
                begin
                    if (cnt_q == 4'h1)
                    begin
                        drv_d = 1'b1; // [R6]
                        st_d  = (st_q == HS_START) ? HS_START_HI : HS_STOP_HI;
                    end
                    else
                    begin
                        cnt_d = cnt_q - 4'h1;
                    end
                end
                HS_START_HI:
                begin
                    oe_n_d  = 1'b1; // [R6]
                    phase_d = PH_TURN;
                    frame_d = FRAME_INIT;
                    cap_d   = '0;
                    st_d    = HS_FRAMES;
                end
                HS_FRAMES:
                begin
                    case (phase_q)
                        PH_TURN:
                        begin
                            if (frame_q == LAST_FRAME)
                            begin
                                drv_d   = 1'b0; // [R16]
                                oe_n_d  = 1'b0;
                                cnt_d   = quiet_next_in ? STOP_QUIET : STOP_CONT; // [R14]
                                quiet_d = quiet_next_in;
                                st_d    = HS_STOP; // [R3]
                            end
                            else
                            begin
                                phase_d = PH_SAMPLE; // [R10]
                                frame_d = frame_q + 6'h01;
                            end
                        end
                        PH_SAMPLE:
                        begin
                            cap_d[frame_q[4:0]] = ~line_s2_q; // [R17]
                            phase_d             = PH_RECOV;
                        end
                        default:
                        begin
                            phase_d = PH_TURN;
                        end
                    endcase
                end
                HS_STOP_HI:
                begin
                    oe_n_d = 1'b1;
                    irq_d  = cap_q;
                    done_d = 1'b1;
                    st_d   = HS_IDLE;
                end
                default:
                begin
                    st_d = HS_IDLE;
                end
            endcase
        end
        busy_d = (st_d != HS_IDLE);
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q    <= HS_IDLE;
            phase_q <= PH_TURN;
            frame_q <= FRAME_INIT;
            cnt_q   <= 4'h0;
            quiet_q <= 1'b0; // [R8]
            req_q   <= 1'b0;
            drv_q   <= 1'b1;
            oe_n_q  <= 1'b1;
            cap_q   <= '0;
            irq_q   <= '0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            phase_q <= phase_d;
            frame_q <= frame_d;
            cnt_q   <= cnt_d;
            quiet_q <= quiet_d;
            req_q   <= req_d;
            drv_q   <= drv_d;
            oe_n_q  <= oe_n_d;
            cap_q   <= cap_d;
            irq_q   <= irq_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
        end
    end

    assign link.host_out  = drv_q;
    assign link.host_oe_n = oe_n_q;
    assign irq_out        = irq_q;
    assign cycle_done_out = done_q;
    assign busy_out       = busy_q;
    assign quiet_mode_out = quiet_q;
endmodule

// [src/sirq_device.sv]
// peripheral end: reports interrupt levels in its frames on the shared line
`timescale 1ns/100ps
// Summary of operation
// [R1] all agents drive the line open-drain
// [R2] timing counted in link clock cycles only
// [R3] cycle is start, data frames, one stop
// [R4] quiet mode: device pulls low one clock
// [R5] host then holds low 3 to 7 more
// [R6] host drives high one clock, then releases
// [R7] continuous mode: host starts, low 4 to 8
// [R8] after reset the protocol is in continuous mode
// [R9] count frames from start pulse rising edge
// [R10] frame is sample, recovery, turn-around clocks
// [R11] sample phase: pull low if interrupt active
// [R12] recovery after own low: drive high once
// [R13] turn-around phase: line left undriven
// [R14] stop width 2 quiet, 3 continuous
// [R15] accept next start at once or later
// [R16] only host starts stop after all frames
// [R17] frame n sampled at 2+3(n-1)
// [R18] wake line only when idle and levels changed
// [R19] low pulse outside 4..8 is no start
module sirq_device
(
    input  wire logic                              sys_clk_in,
    input  wire logic                              rst_in,
    input  wire logic [sirq_pkg::NUM_FRAMES-1:0]   irq_in,
    output logic      [sirq_pkg::NUM_FRAMES-1:0]   reported_out,
    output logic                                   quiet_mode_out,
    output logic                                   cycle_active_out,
    output logic                                   bad_start_out,
    output logic                                   stop_seen_out,
    sirq_if.device                                 link
);
    import sirq_pkg::*;

    logic                   clk_s1_q;
    logic                   clk_s2_q;
    logic                   clk_s3_q;
    logic                   line_s1_q;
    logic                   line_s2_q;
    logic                   tick;
    logic [5:0]             frame_nx;
    sirq_dev_state_t        st_q, st_d;
    sirq_phase_t            phase_q, phase_d;
    logic [5:0]             frame_q, frame_d;
    logic [3:0]             low_cnt_q, low_cnt_d;
    logic                   quiet_q, quiet_d;
    logic                   drv_q, drv_d;
    logic                   oe_n_q, oe_n_d;
    logic [NUM_FRAMES-1:0]  rep_q, rep_d;
    logic                   active_q, active_d;
    logic                   bad_q, bad_d;
    logic                   stop_q, stop_d;

    // the link clock is sampled like any pin; its rising edge gives one tick
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            // reset high: a link clock already high at release gives no false tick
            clk_s1_q  <= 1'b1;
            clk_s2_q  <= 1'b1;
            clk_s3_q  <= 1'b1;
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
        end
        else
        begin
            clk_s1_q  <= link.link_clk;
            clk_s2_q  <= clk_s1_q;
            clk_s3_q  <= clk_s2_q;
            line_s1_q <= link.shared_interrupt_line;
            line_s2_q <= line_s1_q;
        end
    end

    // line and clock share the same sync delay, so sampling stays aligned
    assign tick = clk_s2_q & ~clk_s3_q; // [R2]

    // saturating frame index; the first increment wraps the start value to 0
    assign frame_nx = (frame_q == FRAME_SAT) ? frame_q : frame_q + 6'h01;

    always_comb
    begin
        st_d      = st_q;
        phase_d   = phase_q;
        frame_d   = frame_q;
        low_cnt_d = low_cnt_q;
        quiet_d   = quiet_q;
        drv_d     = drv_q;
        oe_n_d    = oe_n_q;
        rep_d     = rep_q;
        active_d  = active_q;
        bad_d     = 1'b0;
        stop_d    = 1'b0;
        if (tick)
        begin
            // width of the low pulse that is now ending, in link clocks
            if (line_s2_q)
            begin
                low_cnt_d = 4'h0;
            end
            else if (low_cnt_q != LOW_SAT)
            begin
                low_cnt_d = low_cnt_q + 4'h1;
            end
            case (st_q)
                DS_IDLE:
                begin
                    drv_d  = 1'b1;
                    oe_n_d = 1'b1;
                    if (line_s2_q && low_cnt_q != 4'h0)
                    begin
                        if (low_cnt_q >= START_MIN && low_cnt_q <= START_MAX) // [R19]
                        begin
                            // rising edge closes the start pulse
                            st_d     = DS_FRAMES; // [R9]
                            phase_d  = PH_TURN;
                            frame_d  = FRAME_INIT;
                            rep_d    = irq_in;
                            active_d = 1'b1;
                        end
                        else
                        begin
                            bad_d = 1'b1; // [R19]
                        end
                    end
                    else if (quiet_q && line_s2_q && irq_in != rep_q) // [R18]
                    begin
                        // one low clock wakes everyone; host takes over next clock
                        drv_d  = 1'b0; // [R4]
                        oe_n_d = 1'b0; // [R1]
                        st_d   = DS_WAKE;
                    end
                end
                DS_WAKE:
                begin
                    drv_d  = 1'b1; // [R4]
                    oe_n_d = 1'b1;
                    st_d   = DS_IDLE;
                end
                DS_FRAMES:
                begin
                    if (line_s2_q && low_cnt_q >= STOP_QUIET)
                    begin
                        // own sample pulses last one clock, so two or more is a stop
                        quiet_d  = (low_cnt_q == STOP_QUIET); // [R14]
                        drv_d    = 1'b1;
                        oe_n_d   = 1'b1;
                        active_d = 1'b0;
                        stop_d   = 1'b1; // [R3]
                        st_d     = DS_IDLE; // [R15]
                    end
                    else
                    begin
                        case (phase_q)
                            PH_TURN:
                            begin
                                phase_d = PH_SAMPLE; // [R10]
                                frame_d = frame_nx; // [R17]
                                drv_d   = 1'b1;
                                oe_n_d  = 1'b1;
                                if (frame_nx < NUM_FRAMES && rep_q[frame_nx[4:0]])
                                begin
                                    drv_d  = 1'b0; // [R11]
                                    oe_n_d = 1'b0;
                                end
                            end
                            PH_SAMPLE:
                            begin
                                phase_d = PH_RECOV;
                                if (!oe_n_q)
                                begin
                                    drv_d = 1'b1; // [R12]
                                end
                            end
                            default:
                            begin
                                phase_d = PH_TURN;
                                drv_d   = 1'b1;
                                oe_n_d  = 1'b1; // [R13]
                            end
                        endcase
                    end
                end
                default:
                begin
                    st_d   = DS_IDLE;
                    drv_d  = 1'b1;
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q      <= DS_IDLE;
            phase_q   <= PH_TURN;
            frame_q   <= FRAME_INIT;
            low_cnt_q <= 4'h0;
            quiet_q   <= 1'b0; // [R8]
            drv_q     <= 1'b1;
            oe_n_q    <= 1'b1;
            rep_q     <= '0;
            active_q  <= 1'b0;
            bad_q     <= 1'b0;
            stop_q    <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            phase_q   <= phase_d;
            frame_q   <= frame_d;
            low_cnt_q <= low_cnt_d;
            quiet_q   <= quiet_d;
            drv_q     <= drv_d;
            oe_n_q    <= oe_n_d;
            rep_q     <= rep_d;
            active_q  <= active_d;
            bad_q     <= bad_d;
            stop_q    <= stop_d;
        end
    end

    assign link.dev_out     = drv_q;
    assign link.dev_oe_n    = oe_n_q;
    assign reported_out     = rep_q;
    assign quiet_mode_out   = quiet_q;
    assign cycle_active_out = active_q;
    assign bad_start_out    = bad_q;
    assign stop_seen_out    = stop_q;
endmodule

// [verif/sirq_properties.sv]
// assertions on the shared serial interrupt line between host and device ends
`timescale 1ns/100ps
module sirq_properties
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic dev_out,
    input wire logic dev_oe_n,
    input wire logic host_out,
    input wire logic host_oe_n
);
    logic       dl, dh, hl, hh;
    logic       hh_q, st_q, st_d;
    logic [9:0] slot_q, slot_d;
    logic [6:0] low_q, low_d;

    assign dl = !dev_oe_n && !dev_out;
    assign dh = !dev_oe_n && dev_out;
    assign hl = !host_oe_n && !host_out;
    assign hh = !host_oe_n && host_out;

    // slot restarts only after a start high, so stop highs and wakes are not framed
    always_comb
    begin
        low_d = hl ? low_q + {6'h00, low_q != 7'h7f} : 7'h00;
        st_d = (!hl && low_q != 7'h00) ? (low_q >= 7'h20) : st_q;
        if (hh_q && !hh && st_q)
            slot_d = 10'h000;
        else if (hl || slot_q == 10'h3ff)
            slot_d = 10'h3ff;
        else
            slot_d = slot_q + 10'h001;
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            hh_q   <= 1'b0;
            st_q   <= 1'b0;
            slot_q <= 10'h3ff;
            low_q  <= 7'h00;
        end
        else
        begin
            hh_q   <= hh;
            st_q   <= st_d;
            slot_q <= slot_d;
            low_q  <= low_d;
        end
    end

    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    a_no_contention: assert property (dev_oe_n || host_oe_n)
        else $error("both ends drive the line");
    a_reset_released: assert property ($fell(rst_in) |-> dev_oe_n && host_oe_n)
        else $error("line held after reset");
    a_sample_one_period: assert property ($rose(dl) |-> dl [*8] ##1 !dl)
        else $error("device low not one link period");
    a_recovery_follows: assert property ($rose(dh) |-> $past(dl))
        else $error("device high without own low before");
    a_recovery_then_turn: assert property ($rose(dh) |-> dh [*8] ##1 dev_oe_n)
        else $error("device recovery or turn-around wrong");
    a_host_high_release: assert property ($fell(hl) |-> hh [*8] ##1 host_oe_n)
        else $error("host high after low wrong");
    a_host_low_width: assert property ($fell(hl) |->
        low_q inside {7'h10, 7'h18, 7'h20, 7'h28, 7'h30, 7'h38, 7'h40})
        else $error("host low width out of range");
    a_frame_slot: assert property ($rose(dl) && slot_q < 10'h1ff |->
        slot_q % 10'h018 == 10'h007)
        else $error("device sample outside its frame slot");

    c_quiet_wake: cover property ($rose(dl) && slot_q == 10'h3ff);
    c_stop_quiet: cover property ($fell(hl) && low_q == 7'h10);
    c_last_frame: cover property ($rose(dl) && slot_q == 10'h1e7);
endmodule

// [verif/test_serial_irq_slave.sv]
// self-checking bench: host and device joined, plus a device driven by hand
`timescale 1ns/100ps
module test_serial_irq_slave;
    import sirq_pkg::*;
    logic                  sys_clk, rst, lclk, req, qn, hb_o, hb_oe_n;
    logic                  done, busy, hqm, dqm, qb, act, bad, stp;
    logic [2:0]            ext;
    logic [NUM_FRAMES-1:0] irq, irq_b, got, rep, rep_b;
    logic [NUM_FRAMES-1:0] pats [6];
    int                    n_mismatch, comparisons, run, nb, ns;
    int                    runs [$];

    sirq_if link_a ();
    sirq_if link_b ();
    assign link_a.link_clk = lclk;
    assign link_b.link_clk = lclk;
    assign link_b.host_out = hb_o;
    assign link_b.host_oe_n = hb_oe_n;

    sirq_host i_sirq_host (.sys_clk_in(sys_clk), .rst_in(rst), .start_req_in(req),
        .quiet_next_in(qn), .start_ext_in(ext), .irq_out(got), .cycle_done_out(done),
        .busy_out(busy), .quiet_mode_out(hqm), .link(link_a));
    sirq_device i_sirq_device (.sys_clk_in(sys_clk), .rst_in(rst), .irq_in(irq),
        .reported_out(rep), .quiet_mode_out(dqm), .cycle_active_out(),
        .bad_start_out(), .stop_seen_out(), .link(link_a));
    sirq_device i_sirq_device_b (.sys_clk_in(sys_clk), .rst_in(rst), .irq_in(irq_b),
        .reported_out(rep_b), .quiet_mode_out(qb), .cycle_active_out(act),
        .bad_start_out(bad), .stop_seen_out(stp), .link(link_b));
    sirq_properties i_sirq_properties (.sys_clk_in(sys_clk), .rst_in(rst),
        .dev_out(link_a.dev_out), .dev_oe_n(link_a.dev_oe_n),
        .host_out(link_a.host_out), .host_oe_n(link_a.host_oe_n));

    always #20 sys_clk = ~sys_clk;

    // lengths of low runs on the joined line, in sys cycles
    always @(posedge sys_clk)
    begin
        if (bad === 1'b1) nb++;
        if (stp === 1'b1) ns++;
        if (link_a.shared_interrupt_line === 1'b0) run++;
        else if (run != 0)
        begin
            runs.push_back(run);
            run = 0;
        end
    end

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic wait_done();
        for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge sys_clk);
        if (done !== 1'b1)
        begin
            n_mismatch++;
            $display("Error at %0t: cycle never completed", $time);
            print_verdict();
        end
    endtask

    // one cycle, started by request (continuous) or by a level change (quiet)
    task automatic cycle(input logic r, input logic [2:0] e, input logic q,
                         input logic [NUM_FRAMES-1:0] p);
        runs.delete();
        irq = p;
        ext = e;
        qn = q;
        req = r;
        @(negedge sys_clk);
        req = 1'b0;
        wait_done();
        check(got, p, "frame values at host");
        check(rep, p, "device snapshot");
        check(runs.size(), 2 + $countones(p), "low runs in cycle");
        check(runs[0], 8 * (e + 1), "start width");
        check(runs[runs.size() - 1], q ? 16 : 24, "stop width");
        check({hqm, dqm}, {q, q}, "next mode");
    endtask

    // hand driver for the second line: low, then high, then released
    task automatic b_pulse(input int lo, input int hi);
        @(posedge lclk);
        @(negedge sys_clk);
        hb_oe_n = 1'b0;
        hb_o = 1'b0;
        repeat (8 * lo) @(negedge sys_clk);
        hb_o = 1'b1;
        repeat (8 * hi) @(negedge sys_clk);
        hb_oe_n = 1'b1;
        // two link periods: the far end sees the release only at a later tick
        repeat (16) @(negedge sys_clk);
    endtask

    initial
    begin
        lclk = 1'b0;
        #13;
        forever #160 lclk = ~lclk;
    end

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {req, qn, hb_o, hb_oe_n} = 4'h3;
        ext = 3'h3;
        irq = '0;
        irq_b = 21'h000001;
        pats = '{21'h000001, 21'h100000, 21'h155555, 21'h0aaaaa, 21'h1fffff, 21'h000000};
        {n_mismatch, comparisons, run, nb, ns} = '0;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        check({hqm, dqm, busy}, 3'h0, "state after reset");
        for (int k = 0; k < 6; k++) cycle(1'b1, 3'(3 + k % 5), 1'b0, pats[k]);
        cycle(1'b1, 3'h5, 1'b1, 21'h000010);
        runs.delete();
        // quiet with unchanged levels must stay silent
        repeat (200) @(negedge sys_clk);
        check({busy, runs.size() != 0}, 2'h0, "quiet idle woke");
        cycle(1'b0, 3'h7, 1'b1, 21'h000400);
        cycle(1'b0, 3'h3, 1'b0, 21'h000000);
        req = 1'b1;
        @(negedge sys_clk);
        req = 1'b0;
        repeat (100) @(negedge sys_clk);
        rst = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        check({got, hqm}, 22'h0, "capture and mode after reset");
        cycle(1'b1, 3'h4, 1'b0, 21'h0f0f0f);
        b_pulse(2, 0);
        b_pulse(10, 0);
        check({nb[7:0], act}, {8'h02, 1'b0}, "short and long lows refused");
        b_pulse(5, 1);
        check({act, rep_b}, {1'b1, irq_b}, "valid start taken");
        repeat (496) @(negedge sys_clk);
        b_pulse(3, 1);
        check({ns[7:0], qb, act}, {8'h01, 2'h0}, "stop ends cycle, continuous");
        print_verdict();
    end
endmodule
